// file: logic/crg_pkg.sv
// Purpose: Shared constants and types for the core register, flag and stack block.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes:   Data-space offsets, widths, stack depth and command codes live here.
package crg_pkg;

  // ********************************************************************
  // Widths and sizes
  // ********************************************************************
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PC_W        = 12;
  localparam int unsigned STACK_DEPTH = 6;
  localparam int unsigned DEPTH_W     = 3;

  // ********************************************************************
  // Data-space offsets
  // ********************************************************************
  localparam logic [7:0] ADDR_POINTER_ONE      = 8'h80;
  localparam logic [7:0] ADDR_POINTER_TWO      = 8'h81;
  localparam logic [7:0] ADDR_SHORT_DIRECT_ONE = 8'h82;
  localparam logic [7:0] ADDR_SHORT_DIRECT_TWO = 8'h83;
  localparam logic [7:0] ADDR_ACCUMULATOR      = 8'hff;

  // ********************************************************************
  // Values after reset and the counter increment
  // ********************************************************************
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [11:0] PC_RESET     = 12'h000;
  localparam logic [11:0] PC_INCREMENT = 12'h001;
  localparam logic [2:0]  DEPTH_RESET  = 3'h0;

  // ********************************************************************
  // Types
  // ********************************************************************
  // Flag context; reset selects the non-maskable one.
  typedef enum logic [1:0] {
    CRG_CTX_NORMAL = 2'b00,
    CRG_CTX_IRQ    = 2'b01,
    CRG_CTX_NMI    = 2'b10
  } crg_ctx_t;

  // Program counter update source.
  typedef enum logic [2:0] {
    CRG_PC_HOLD     = 3'b000,
    CRG_PC_NEXT     = 3'b001,
    CRG_PC_JUMP     = 3'b010,
    CRG_PC_CALL     = 3'b011,
    CRG_PC_RELATIVE = 3'b100,
    CRG_PC_RETURN   = 3'b101,
    CRG_PC_RETURN_FROM_INTERRUPT     = 3'b110,
    CRG_PC_VECTOR   = 3'b111
  } crg_pc_op_t;

  // Flag update request from the ALU.
  typedef struct packed {
    logic carry_we;
    logic carry;
    logic zero_we;
    logic zero;
  } crg_flag_upd_t;

  // Data-space access to the core registers.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crg_dacc_t;

  // Program counter command.
  typedef struct packed {
    crg_pc_op_t  op;
    logic [11:0] target;
    logic [7:0]  offset;
    logic        vec_nmi;
  } crg_pc_cmd_t;

endpackage

// file: logic/crg_flags.sv
// Purpose: Three context-switched carry/zero flag pairs.
// Assumes: Context is supplied by the core; one update per cycle.
// Notes:   Only the pair of the active context is written or seen.
`timescale 1ns/1ns
module crg_flags (
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  input  crg_pkg::crg_ctx_t           ctx_i,
  input  crg_pkg::crg_flag_upd_t      upd_i,
  output logic                        carry_o,
  output logic                        zero_o
);

  // ********************************************************************
  // Flag storage
  // ********************************************************************
  logic [2:0] carry_reg;
  logic [2:0] zero_reg;
  logic [1:0] idx;

  assign idx = ctx_i;

  // Only the active pair changes; switching contexts preserves all pairs.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      carry_reg <= 3'h0;
      zero_reg  <= 3'h0;
    end else begin
      if (upd_i.carry_we) begin
        carry_reg[idx] <= upd_i.carry; // RULE13 RULE12
      end
      if (upd_i.zero_we) begin
        zero_reg[idx] <= upd_i.zero; // RULE14 RULE12
      end
    end
  end

  // The active pair is the only one visible.
  assign carry_o = carry_reg[idx]; // RULE10
  assign zero_o  = zero_reg[idx];

endmodule

// file: logic/crg_stack.sv
// Purpose: Six-level return address LIFO, no stack pointer visible.
// Assumes: Push and pop never requested together.
// Notes:   Overflow drops the oldest entry; underflow reports empty.
`timescale 1ns/1ns
module crg_stack #(
  parameter int unsigned DEPTH = crg_pkg::STACK_DEPTH
) (
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic         push_i,
  input  wire logic         pop_i,
  input  wire logic [11:0]  push_data_i,
  output logic [11:0]       top_o,
  output logic              empty_o,
  output logic [2:0]        depth_o
);

  // ********************************************************************
  // Storage and occupancy
  // ********************************************************************
  logic [11:0] level_reg [DEPTH];
  logic [2:0]  depth_reg;

  // Entries shift deeper on push and up on pop; the last entry falls off.
  always_ff @(posedge mclk_i) begin
    if (push_i) begin
      level_reg[0] <= push_data_i; // RULE17
      for (int i = 1; i < DEPTH; i++) begin
        level_reg[i] <= level_reg[i-1];
      end
    end else if (pop_i) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        level_reg[i] <= level_reg[i+1]; // RULE18
      end
    end
  end

  // Occupancy saturates at both ends so overflow and underflow are benign.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      depth_reg <= crg_pkg::DEPTH_RESET;
    end else if (push_i && depth_reg != 3'(DEPTH)) begin
      depth_reg <= depth_reg + 3'h1;
    end else if (pop_i && depth_reg != 3'h0) begin
      depth_reg <= depth_reg - 3'h1; // RULE19 RULE20
    end
  end

  assign top_o   = level_reg[0];
  assign empty_o = (depth_reg == 3'h0);
  assign depth_o = depth_reg;

endmodule

// file: logic/crg_core_regs.sv
// Purpose: Programmer-visible core state: accumulator, pointers, PC, flags, stack.
// Assumes: Sequencer issues one PC command per machine step; inputs synchronous.
// Notes:   Notes on behaviour list follows.
//
// Notes on behaviour
// RULE1: Eight-bit accumulator, also read and written at data-space FFh.
// RULE2: First pointer at 80h, second pointer at 81h in data space.
// RULE3: Short-direct registers at 82h and 83h, also reachable by direct addressing.
// RULE4: Pointers give the indirect address and are ordinary data-space registers too.
// RULE5: Twelve-bit program counter covering 4096 bytes of program space.
// RULE6: Space beyond 4096 bytes uses an outside bank register, not a wider counter.
// RULE7: Counter advances after the current instruction address has been read.
// RULE8: Jump, call, vector, return and increment-by-one load the counter.
// RULE9: Relative branch adds signed offset to counter through the adder.
// RULE10: Three carry/zero pairs: normal, interrupt and non-maskable.
// RULE11: Interrupt entry switches pair; return-from-interrupt restores the previous.
// RULE12: Each pair visible only in its context; switching never clears it.
// RULE13: Active carry from arithmetic carry or borrow, bit test, feeds rotate.
// RULE14: Active zero set when last arithmetic or logic result is zero.
// RULE15: After reset the core runs in non-maskable context.
// RULE16: Six-entry twelve-bit hardware return stack, no pointer register.
// RULE17: Call or interrupt shifts entries deeper; counter enters level one.
// RULE18: Return loads level one into counter and shifts deeper entries up.
// RULE19: Beyond six nestings the stack stays deepest; oldest address lost.
// RULE20: Return on empty stack keeps stack at top; next instruction runs.
// RULE21: Only the counter is pushed; accumulator and others are not saved.
`timescale 1ns/1ns
module crg_core_regs #(
  parameter logic [11:0] RESET_VECTOR = 12'hffe,
  parameter logic [11:0] NMI_VECTOR   = 12'hffc
) (
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  input  crg_pkg::crg_dacc_t          dacc_i,
  output logic [7:0]                  dacc_rdata_o,
  output logic                        dacc_hit_o,
  input  wire logic                   acc_we_i,
  input  wire logic [7:0]             acc_wdata_i,
  input  wire logic                   fetch_done_i,
  input  crg_pkg::crg_pc_cmd_t        pc_cmd_i,
  input  wire logic [11:0]            irq_vector_i,
  input  crg_pkg::crg_flag_upd_t      flag_upd_i,
  output logic [11:0]                 program_counter_o,
  output logic [7:0]                  accumulator_o,
  output logic [7:0]                  pointer_one_o,
  output logic [7:0]                  pointer_two_o,
  output logic [7:0]                  short_direct_one_o,
  output logic [7:0]                  short_direct_two_o,
  output logic                        carry_o,
  output logic                        zero_o,
  output crg_pkg::crg_ctx_t           ctx_o,
  output logic [2:0]                  stack_depth_o
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [7:0]          accumulator_reg;
  logic [7:0]          pointer_one_reg;
  logic [7:0]          pointer_two_reg;
  logic [7:0]          short_direct_one_reg;
  logic [7:0]          short_direct_two_reg;
  logic [11:0]         program_counter_reg;
  logic [11:0]         program_counter_next;
  crg_pkg::crg_ctx_t   ctx_reg;
  crg_pkg::crg_ctx_t   ctx_next;
  crg_pkg::crg_ctx_t   saved_ctx_reg;
  crg_pkg::crg_ctx_t   saved_ctx_next;
  logic                stack_push;
  logic                stack_pop;
  logic [11:0]         stack_top;
  logic                stack_empty;
  logic                is_entry;
  logic                is_return;

  // Data-space write strobe for one offset.
  function automatic logic dwrite(input crg_pkg::crg_dacc_t acc, input logic [7:0] a);
    dwrite = acc.wr && (acc.addr == a);
  endfunction

  // Sign-extend an eight-bit branch offset to counter width.
  function automatic logic [11:0] sext_offset(input logic [7:0] off);
    sext_offset = {{4{off[7]}}, off};
  endfunction

  // ********************************************************************
  // Data-space registers
  // ********************************************************************
  // The ALU result write takes priority over a data-space write to FFh.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      accumulator_reg <= crg_pkg::REG_RESET;
    end else if (acc_we_i) begin
      accumulator_reg <= acc_wdata_i; // RULE1
    end else if (dwrite(dacc_i, crg_pkg::ADDR_ACCUMULATOR)) begin
      accumulator_reg <= dacc_i.wdata; // RULE1
    end
  end

  // Pointers double as ordinary data-space registers.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pointer_one_reg <= crg_pkg::REG_RESET;
      pointer_two_reg <= crg_pkg::REG_RESET;
    end else begin
      if (dwrite(dacc_i, crg_pkg::ADDR_POINTER_ONE)) begin
        pointer_one_reg <= dacc_i.wdata; // RULE2 RULE4
      end
      if (dwrite(dacc_i, crg_pkg::ADDR_POINTER_TWO)) begin
        pointer_two_reg <= dacc_i.wdata; // RULE2 RULE4
      end
    end
  end

  // Short-direct registers; every addressing mode funnels here by offset.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      short_direct_one_reg <= crg_pkg::REG_RESET;
      short_direct_two_reg <= crg_pkg::REG_RESET;
    end else begin
      if (dwrite(dacc_i, crg_pkg::ADDR_SHORT_DIRECT_ONE)) begin
        short_direct_one_reg <= dacc_i.wdata; // RULE3
      end
      if (dwrite(dacc_i, crg_pkg::ADDR_SHORT_DIRECT_TWO)) begin
        short_direct_two_reg <= dacc_i.wdata; // RULE3
      end
    end
  end

  // Read mux; other offsets belong to RAM or peripherals and miss here.
  always_comb begin
    dacc_rdata_o = 8'h00;
    dacc_hit_o   = 1'b1;
    case (dacc_i.addr)
      crg_pkg::ADDR_ACCUMULATOR:      dacc_rdata_o = accumulator_reg; // RULE1
      crg_pkg::ADDR_POINTER_ONE:      dacc_rdata_o = pointer_one_reg; // RULE2
      crg_pkg::ADDR_POINTER_TWO:      dacc_rdata_o = pointer_two_reg;
      crg_pkg::ADDR_SHORT_DIRECT_ONE: dacc_rdata_o = short_direct_one_reg; // RULE3
      crg_pkg::ADDR_SHORT_DIRECT_TWO: dacc_rdata_o = short_direct_two_reg;
      default:                        dacc_hit_o   = 1'b0;
    endcase
  end

  // ********************************************************************
  // Program counter
  // ********************************************************************
  assign is_entry  = (pc_cmd_i.op == crg_pkg::CRG_PC_CALL) ||
                     (pc_cmd_i.op == crg_pkg::CRG_PC_VECTOR);
  assign is_return = (pc_cmd_i.op == crg_pkg::CRG_PC_RETURN) ||
                     (pc_cmd_i.op == crg_pkg::CRG_PC_RETURN_FROM_INTERRUPT);

  // Next counter value; bank switching is outside, so the counter wraps at 12 bits.
  always_comb begin
    program_counter_next = program_counter_reg;
    case (pc_cmd_i.op)
      crg_pkg::CRG_PC_HOLD: program_counter_next = program_counter_reg;
      crg_pkg::CRG_PC_NEXT: begin
        if (fetch_done_i) begin
          program_counter_next = program_counter_reg + crg_pkg::PC_INCREMENT; // RULE7 RULE8
        end
      end
      crg_pkg::CRG_PC_JUMP: program_counter_next = pc_cmd_i.target; // RULE8
      crg_pkg::CRG_PC_CALL: program_counter_next = pc_cmd_i.target; // RULE8
      crg_pkg::CRG_PC_RELATIVE: begin
        program_counter_next = program_counter_reg + sext_offset(pc_cmd_i.offset); // RULE9
      end
      crg_pkg::CRG_PC_RETURN, crg_pkg::CRG_PC_RETURN_FROM_INTERRUPT: begin
        // An empty stack leaves the counter to fall through to the next instruction.
        if (stack_empty) begin
          program_counter_next = program_counter_reg + crg_pkg::PC_INCREMENT; // RULE20
        end else begin
          program_counter_next = stack_top; // RULE8 RULE18
        end
      end
      crg_pkg::CRG_PC_VECTOR: begin
        program_counter_next = pc_cmd_i.vec_nmi ? NMI_VECTOR : irq_vector_i; // RULE8
      end
      default: program_counter_next = program_counter_reg;
    endcase
  end

  // Twelve-bit counter; reset loads the reset vector.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      program_counter_reg <= RESET_VECTOR; // RULE5 RULE6 RULE8
    end else begin
      program_counter_reg <= program_counter_next;
    end
  end

  // ********************************************************************
  // Flag context
  // ********************************************************************
  // A maskable entry remembers the context it left; NMI entry remembers too.
  // Only one level is remembered, matching the single nesting the contexts allow.
  always_comb begin
    ctx_next       = ctx_reg;
    saved_ctx_next = saved_ctx_reg;
    case (pc_cmd_i.op)
      crg_pkg::CRG_PC_VECTOR: begin
        saved_ctx_next = ctx_reg;
        ctx_next       = pc_cmd_i.vec_nmi ? crg_pkg::CRG_CTX_NMI
                                          : crg_pkg::CRG_CTX_IRQ; // RULE11
      end
      crg_pkg::CRG_PC_RETURN_FROM_INTERRUPT: begin
        ctx_next       = saved_ctx_reg; // RULE11
        saved_ctx_next = crg_pkg::CRG_CTX_NORMAL;
      end
      default: begin
        ctx_next       = ctx_reg;
        saved_ctx_next = saved_ctx_reg;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ctx_reg       <= crg_pkg::CRG_CTX_NMI; // RULE15
      saved_ctx_reg <= crg_pkg::CRG_CTX_NORMAL;
    end else begin
      ctx_reg       <= ctx_next;
      saved_ctx_reg <= saved_ctx_next;
    end
  end

  crg_flags u_flags (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ctx_i    (ctx_reg),
    .upd_i    (flag_upd_i),
    .carry_o  (carry_o),
    .zero_o   (zero_o)
  );

  // ********************************************************************
  // Return stack
  // ********************************************************************
  // Only the return address is pushed; data registers are software's job.
  assign stack_push = is_entry; // RULE17 RULE21
  assign stack_pop  = is_return; // RULE18

  crg_stack #(
    .DEPTH (crg_pkg::STACK_DEPTH)
  ) u_stack (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .push_i      (stack_push),
    .pop_i       (stack_pop),
    .push_data_i (program_counter_reg), // RULE16
    .top_o       (stack_top),
    .empty_o     (stack_empty),
    .depth_o     (stack_depth_o)
  );

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign program_counter_o  = program_counter_reg;
  assign accumulator_o      = accumulator_reg;
  assign pointer_one_o      = pointer_one_reg; // RULE4
  assign pointer_two_o      = pointer_two_reg;
  assign short_direct_one_o = short_direct_one_reg;
  assign short_direct_two_o = short_direct_two_reg;
  assign ctx_o              = ctx_reg;

endmodule

// file: tb/crg_core_regs_props.sv
// Purpose: Port-level checks on the core register block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ns
module crg_core_regs_props #(
  parameter logic [11:0] RESET_VECTOR = 12'hffe,
  parameter logic [11:0] NMI_VECTOR   = 12'hffc
) (
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  input  crg_pkg::crg_dacc_t     dacc_i,
  input  wire logic              dacc_hit_o,
  input  wire logic              acc_we_i,
  input  wire logic              fetch_done_i,
  input  crg_pkg::crg_pc_cmd_t   pc_cmd_i,
  input  wire logic [11:0]       irq_vector_i,
  input  crg_pkg::crg_flag_upd_t flag_upd_i,
  input  wire logic [11:0]       program_counter_o,
  input  wire logic [7:0]        accumulator_o,
  input  wire logic [7:0]        pointer_one_o,
  input  wire logic              carry_o,
  input  wire logic              zero_o,
  input  crg_pkg::crg_ctx_t      ctx_o,
  input  wire logic [2:0]        stack_depth_o
);
  // ********
  // Command decode and properties
  // ********
  // Decoding once keeps each property to the relation it checks.
  logic        jmp, nxt, rel, cal, ret, rti, vec;
  logic [11:0] sext;
  assign jmp  = pc_cmd_i.op == crg_pkg::CRG_PC_JUMP;
  assign nxt  = pc_cmd_i.op == crg_pkg::CRG_PC_NEXT;
  assign rel  = pc_cmd_i.op == crg_pkg::CRG_PC_RELATIVE;
  assign cal  = pc_cmd_i.op == crg_pkg::CRG_PC_CALL;
  assign ret  = pc_cmd_i.op == crg_pkg::CRG_PC_RETURN;
  assign rti  = pc_cmd_i.op == crg_pkg::CRG_PC_RETURN_FROM_INTERRUPT;
  assign vec  = pc_cmd_i.op == crg_pkg::CRG_PC_VECTOR;
  assign sext = {{4{pc_cmd_i.offset[7]}}, pc_cmd_i.offset};

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  AST_RESET_STATE: assert property ($rose(resetn_i) |-> ctx_o == crg_pkg::CRG_CTX_NMI
    && stack_depth_o == 3'h0 && program_counter_o == RESET_VECTOR)
    else $error("bad reset state");
  AST_LOAD: assert property (jmp || cal |=> program_counter_o == $past(pc_cmd_i.target))
    else $error("target not loaded");
  AST_NEXT: assert property (nxt && fetch_done_i |=>
    program_counter_o == $past(program_counter_o) + 12'h001)
    else $error("no increment");
  AST_NEXT_WAIT: assert property (nxt && !fetch_done_i |=> $stable(program_counter_o))
    else $error("early increment");
  AST_RELATIVE: assert property (rel |=>
    program_counter_o == $past(program_counter_o) + $past(sext))
    else $error("bad branch sum");
  AST_PUSH: assert property (cal && stack_depth_o < 3'h6 |=>
    stack_depth_o == $past(stack_depth_o) + 3'h1)
    else $error("no push");
  AST_DEEP: assert property ((cal || vec) && stack_depth_o == 3'h6 |=> stack_depth_o == 3'h6)
    else $error("left deepest level");
  AST_EMPTY_RET: assert property (ret && stack_depth_o == 3'h0 |=>
    program_counter_o == $past(program_counter_o) + 12'h001 && stack_depth_o == 3'h0)
    else $error("bad empty return");
  AST_VECTOR: assert property (vec |=> ctx_o == ($past(pc_cmd_i.vec_nmi) ?
    crg_pkg::CRG_CTX_NMI : crg_pkg::CRG_CTX_IRQ) && program_counter_o ==
    ($past(pc_cmd_i.vec_nmi) ? NMI_VECTOR : $past(irq_vector_i)))
    else $error("bad vector entry");
  AST_ONLY_PC: assert property (cal && !acc_we_i && !dacc_i.wr |=>
    $stable(accumulator_o) && $stable(pointer_one_o))
    else $error("data register changed");
  AST_HIT: assert property (dacc_hit_o == (dacc_i.addr inside
    {8'h80, 8'h81, 8'h82, 8'h83, 8'hff}))
    else $error("bad hit decode");
  AST_CARRY: assert property (flag_upd_i.carry_we && !vec && !rti |=>
    carry_o == $past(flag_upd_i.carry))
    else $error("carry not written");
  AST_ZERO: assert property (flag_upd_i.zero_we && !vec && !rti |=>
    zero_o == $past(flag_upd_i.zero))
    else $error("zero not written");

  cover property (cal && stack_depth_o == 3'h6);
  cover property (ret && stack_depth_o == 3'h0);
  cover property (vec && !pc_cmd_i.vec_nmi);
endmodule

bind crg_core_regs crg_core_regs_props #(
  .RESET_VECTOR(RESET_VECTOR), .NMI_VECTOR(NMI_VECTOR)
) u_props (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .dacc_i(dacc_i), .dacc_hit_o(dacc_hit_o),
  .acc_we_i(acc_we_i), .fetch_done_i(fetch_done_i), .pc_cmd_i(pc_cmd_i),
  .irq_vector_i(irq_vector_i), .flag_upd_i(flag_upd_i),
  .program_counter_o(program_counter_o), .accumulator_o(accumulator_o),
  .pointer_one_o(pointer_one_o), .carry_o(carry_o), .zero_o(zero_o),
  .ctx_o(ctx_o), .stack_depth_o(stack_depth_o)
);

// file: tb/crg_seq_model.sv
// Purpose: Sequencer and ALU model that drives the core register block.
// Assumes: Callers enter each task 1 ns after a rising clock edge.
// Notes:   A request stands until the next task replaces it.
`timescale 1ns/1ns
module crg_seq_model #(
  parameter logic [11:0] VEC = 12'h3a0
) (
  input  wire logic              mclk_i,
  output crg_pkg::crg_dacc_t     dacc_o,
  output crg_pkg::crg_pc_cmd_t   pc_cmd_o,
  output logic                   fetch_done_o,
  output crg_pkg::crg_flag_upd_t flag_upd_o,
  output logic                   acc_we_o,
  output logic [7:0]             acc_wdata_o,
  output logic [11:0]            irq_vector_o
);
  // ********
  // Request drivers
  // ********
  // Every task sets all request signals once, so none is written twice.
  task automatic go(input crg_pkg::crg_pc_cmd_t c, input logic fd,
                    input crg_pkg::crg_dacc_t d, input logic alu, input logic [3:0] f);
    pc_cmd_o = c;
    fetch_done_o = fd;
    dacc_o = d;
    acc_we_o = alu;
    acc_wdata_o = ~d.wdata; // The ALU value differs so a lost priority shows.
    flag_upd_o = crg_pkg::crg_flag_upd_t'(f);
    irq_vector_o = VEC;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic cmd(input crg_pkg::crg_pc_op_t op, input logic [11:0] tg,
                     input logic [7:0] off, input logic nmi, fd);
    go('{op, tg, off, nmi}, fd, '0, 1'b0, 4'h0);
  endtask

  task automatic acc(input logic [7:0] a, d, input logic wr, alu);
    go('0, 1'b0, '{wr, a, d}, alu, 4'h0);
  endtask

  task automatic flg(input logic [3:0] f);
    go('0, 1'b0, '0, 1'b0, f);
  endtask
endmodule

// file: tb/test_cpu_core_regs_flags_stack.sv
// Purpose: Self-checking bench for the core register, flag and stack block.
// Assumes: 100 MHz clock; inputs change 1 ns after the rising edge.
// Notes:   Reset vectors are set to distinct values to catch swaps.
`timescale 1ns/1ns
module test_cpu_core_regs_flags_stack;
  localparam logic [11:0] RV = 12'h7f0;
  localparam logic [11:0] NV = 12'h7e0;
  localparam logic [11:0] IV = 12'h3a0;
  logic                   mclk;
  logic                   resetn;
  crg_pkg::crg_dacc_t     dacc;
  crg_pkg::crg_pc_cmd_t   pc_cmd;
  crg_pkg::crg_flag_upd_t fupd;
  crg_pkg::crg_ctx_t      ctx;
  logic                   fetch, acc_we, hit, carry, zero;
  logic [7:0]             acc_wd, rdata, acc, p1, p2, s1, s2;
  logic [11:0]            irq_vec, pc;
  logic [2:0]             depth;
  int                     error_cnt, check_count, cyc;

  crg_seq_model #(.VEC(IV)) sq (.mclk_i(mclk), .dacc_o(dacc), .pc_cmd_o(pc_cmd),
    .fetch_done_o(fetch), .flag_upd_o(fupd), .acc_we_o(acc_we), .acc_wdata_o(acc_wd),
    .irq_vector_o(irq_vec));
  crg_core_regs #(.RESET_VECTOR(RV), .NMI_VECTOR(NV)) uut (.mclk_i(mclk),
    .resetn_i(resetn), .dacc_i(dacc), .dacc_rdata_o(rdata), .dacc_hit_o(hit),
    .acc_we_i(acc_we), .acc_wdata_i(acc_wd), .fetch_done_i(fetch), .pc_cmd_i(pc_cmd),
    .irq_vector_i(irq_vec), .flag_upd_i(fupd), .program_counter_o(pc),
    .accumulator_o(acc), .pointer_one_o(p1), .pointer_two_o(p2),
    .short_direct_one_o(s1), .short_direct_two_o(s2), .carry_o(carry), .zero_o(zero),
    .ctx_o(ctx), .stack_depth_o(depth));

  // ********
  // Clock, timeout and shared tasks
  // ********
  // The ceiling is far above the roughly 65 cycles the tests need.
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input logic [11:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The first held edge idles the model so no stale command follows.
  task automatic do_reset();
    resetn = 1'b0;
    sq.cmd(crg_pkg::CRG_PC_HOLD, '0, '0, '0, '0);
    repeat (11) @(posedge mclk);
    #1;
    resetn = 1'b1;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    chk(pc, RV);
    chk(12'(ctx), 12'h002);
    chk(12'(depth), 12'h000);
    chk(12'({acc, carry, zero}), 12'h000);
    $display("test reset done");
  endtask

  task automatic t_dspace();
    logic [7:0] a [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
    for (int i = 0; i < 5; i++) sq.acc(a[i], 8'h11 * 8'(i + 1), 1'b1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      sq.acc(a[i], 8'h00, 1'b0, 1'b0);
      chk(12'(hit), 12'h001);
      chk(12'(rdata), 12'(8'h11 * 8'(i + 1)));
    end
    chk(12'({p1, p2}), 12'h122);
    chk(12'({s1, s2}), 12'h344);
    sq.acc(8'h84, 8'h99, 1'b1, 1'b0);
    chk(12'({hit, rdata}), 12'h000);
    chk(12'(p1), 12'h011);
    sq.acc(8'hff, 8'h5a, 1'b1, 1'b1);
    chk(12'(acc), 12'h0a5);
    $display("test dspace done");
  endtask

  task automatic t_pc();
    sq.cmd(crg_pkg::CRG_PC_JUMP, 12'hfff, '0, '0, '0);
    chk(pc, 12'hfff);
    sq.cmd(crg_pkg::CRG_PC_NEXT, '0, '0, '0, 1'b1);
    chk(pc, 12'h000);
    sq.cmd(crg_pkg::CRG_PC_NEXT, '0, '0, '0, '0);
    chk(pc, 12'h000);
    sq.cmd(crg_pkg::CRG_PC_RELATIVE, '0, 8'hfe, '0, '0);
    chk(pc, 12'hffe);
    sq.cmd(crg_pkg::CRG_PC_RELATIVE, '0, 8'h05, '0, '0);
    chk(pc, 12'h003);
    $display("test pc done");
  endtask

  task automatic t_stack();
    sq.cmd(crg_pkg::CRG_PC_JUMP, 12'h100, '0, '0, '0);
    for (int i = 0; i < 7; i++) begin
      sq.cmd(crg_pkg::CRG_PC_CALL, 12'h200 + 12'(i), '0, '0, '0);
      chk(12'(depth), (i < 6) ? 12'(i + 1) : 12'h006);
    end
    chk(12'(acc), 12'h0a5);
    for (int i = 0; i < 6; i++) begin
      sq.cmd(crg_pkg::CRG_PC_RETURN, '0, '0, '0, '0);
      chk(pc, 12'h205 - 12'(i));
    end
    sq.cmd(crg_pkg::CRG_PC_RETURN, '0, '0, '0, '0);
    chk(pc, 12'h201);
    chk(12'(depth), 12'h000);
    $display("test stack done");
  endtask

  task automatic t_flags();
    sq.flg(4'b1110);
    chk(12'({carry, zero}), 12'h002);
    sq.cmd(crg_pkg::CRG_PC_VECTOR, '0, '0, '0, '0);
    chk(pc, IV);
    chk(12'({ctx, carry, zero}), 12'h004);
    sq.flg(4'b1011);
    sq.cmd(crg_pkg::CRG_PC_RETURN_FROM_INTERRUPT, '0, '0, '0, '0);
    chk(12'({ctx, carry, zero}), 12'h00a);
    sq.cmd(crg_pkg::CRG_PC_RETURN_FROM_INTERRUPT, '0, '0, '0, '0);
    chk(12'({ctx, carry, zero}), 12'h000);
    sq.flg(4'b1110);
    sq.flg(4'b0011);
    chk(12'({carry, zero}), 12'h003);
    sq.cmd(crg_pkg::CRG_PC_VECTOR, '0, '0, '0, '0);
    chk(12'({ctx, carry, zero}), 12'h005);
    sq.cmd(crg_pkg::CRG_PC_VECTOR, '0, '0, 1'b1, '0);
    chk(pc, NV);
    chk(12'({ctx, carry, zero}), 12'h00a);
    $display("test flags done");
  endtask

  initial begin
    resetn = 1'b0;
    #1;
    do_reset();
    t_reset();
    t_dspace();
    t_pc();
    t_stack();
    t_flags();
    do_reset();
    t_reset();
    complete_run();
  end
endmodule
